//--- pkg/pbw_consts.svh
`ifndef PBW_CONSTS_SVH
`define PBW_CONSTS_SVH

// ********************************
// clock and timebase
// ********************************
`define PBW_CLK_PERIOD_NS    20
`define PBW_TICK_PERIOD_NS   1000000
`define PBW_TICK_CYCLES      (`PBW_TICK_PERIOD_NS / `PBW_CLK_PERIOD_NS)
`define PBW_TICK_W           16

// ********************************
// times in ms, one timebase tick per ms
// ********************************
`define PBW_TIME_W           12
`define PBW_DEBOUNCE_MS      12'd15
`define PBW_SLOW_STEP_MS     12'd250
`define PBW_FAST_STEP_MS     12'd50
`define PBW_FAST_AFTER_MS    12'd1000
`define PBW_IDLE_SAVE_MS     12'd2000
`define PBW_SHUTDOWN_MS      12'd2000
`define PBW_WAKE_SCAN_MS     12'd250
`define PBW_NV_WRITE_MS      12'd10

// ********************************
// tap positions and boot wait count
// ********************************
`define PBW_TOP_TAP          5'h1F
`define PBW_BOTTOM_TAP       5'h00
`define PBW_BOOT_WAIT        2'h3

`endif

//--- pkg/pbw_pkg.sv
package pbw_pkg;

  // control sequencer states
  typedef enum logic [2:0] {
    PBW_RECALL,
    PBW_STANDBY,
    PBW_STEP,
    PBW_MULTI,
    PBW_SHUTDOWN,
    PBW_WAKE,
    PBW_STORE
  } pbw_state_type;

  // the three active-low button pins
  typedef struct packed {
    logic store_enable_n;
    logic down_button_n;
    logic up_button_n;
  } pbw_pins_type;

  // write request toward the non-volatile cell
  typedef struct packed {
    logic       strobe;
    logic [4:0] data;
  } pbw_nv_wr_type;

endpackage

//--- hw/pbw_input_filter.sv
`timescale 1ns/1ps
`include "pbw_consts.svh"

// ********************************
// synchroniser and press timer for one button
// ********************************
module pbw_input_filter #(
  parameter int                CNT_W    = `PBW_TIME_W,
  parameter logic [CNT_W-1:0]  DB_TICKS = `PBW_DEBOUNCE_MS
) (
  // clock, reset and ms tick
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  input  wire logic             tick,
  // pin, active low
  input  wire logic             pin_n,
  // filtered view
  output logic                  pressed,
  output logic [CNT_W-1:0]      held_ms,
  output logic                  qualified,
  output logic                  settled_released
);

  logic             sync1;
  logic             sync2;
  logic             level;
  logic [CNT_W-1:0] cnt;

  // two flops before anything looks at the pin
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sync1 <= 1'b1;
      sync2 <= 1'b1;
      level <= 1'b1;
    end else begin
      sync1 <= pin_n;
      sync2 <= sync1;
      level <= sync2;
    end
  end

  // ms since the last change of level; restarts on every bounce
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= '0;
    end else if (sync2 != level) begin
      cnt <= '0;
    end else if (tick && (cnt != {CNT_W{1'b1}})) begin
      cnt <= cnt + 1'b1;
    end
  end

  assign pressed          = ~level;
  assign held_ms          = level ? '0 : cnt;
  assign qualified        = ~level && (cnt >= DB_TICKS);
  assign settled_released = level && (cnt >= DB_TICKS);

endmodule // pbw_input_filter

//--- hw/pbw_wiper_ctrl.sv
// What this block does
// - ignore presses shorter than debounce window
// - slow scan steps every 250 ms
// - fast scan steps every 50 ms
// - slow first second, then fast scan
// - up increments, down decrements, one tap
// - position decoded to one-of-32 tap select
// - position saturates at both ends
// - multiple buttons: discard, except shutdown request
// - release of held button returns to standby
// - blank store recalls the top tap
// - store low: save after 2 s idle
// - recall stored position at power-up
// - manual mode: store low locks up/down
// - manual store on store press and release
// - store pressed during up/down: no save
// - inputs ignored during write cycle
// - both held 2 s enters shutdown
// - shutdown opens top, selects bottom tap
// - any button over 15 ms leaves shutdown, once all three are released
// - held 250 ms after wake starts scanning
`timescale 1ns/1ps
`include "pbw_consts.svh"

module pbw_wiper_ctrl #(
  parameter int TICK_CYCLES = `PBW_TICK_CYCLES
) (
  // clock and reset
  input  wire logic               clk_sys,
  input  wire logic               rst_n,
  // button pins
  input  wire pbw_pkg::pbw_pins_type pins,
  // non-volatile cell
  input  wire logic [4:0]         nv_recall_data,
  input  wire logic               nv_blank,
  output pbw_pkg::pbw_nv_wr_type  nv_wr,
  // resistor array control
  output logic [31:0]             tap_select,
  output logic                    top_terminal_connect,
  // status
  output logic [4:0]              wiper_position,
  output logic                    store_busy,
  output logic                    shutdown_active
);
  import pbw_pkg::*;

  localparam int TW = `PBW_TIME_W;

  // ********************************
  // timebase
  // ********************************
  logic [`PBW_TICK_W-1:0] tick_cnt;
  logic                   tick;

  // one free-running ms tick serves every timer in the block
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt <= '0;
      tick     <= 1'b0;
    end else if (tick_cnt == `PBW_TICK_W'(TICK_CYCLES - 1)) begin
      tick_cnt <= '0;
      tick     <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 1'b1;
      tick     <= 1'b0;
    end
  end

  // ********************************
  // button filters: 0 up, 1 down, 2 store
  // ********************************
  logic [2:0]    pin_n;
  logic [2:0]    prs;
  logic [2:0]    qual;
  logic [2:0]    rel;
  logic [TW-1:0] held [3];

  assign pin_n = {pins.store_enable_n, pins.down_button_n,
                  pins.up_button_n};

  for (genvar g = 0; g < 3; g++) begin : g_filt
    pbw_input_filter #(
      .CNT_W    (TW),
      .DB_TICKS (`PBW_DEBOUNCE_MS)
    ) u_filt (
      .clk_sys          (clk_sys),
      .rst_n            (rst_n),
      .tick             (tick),
      .pin_n            (pin_n[g]),
      .pressed          (prs[g]),
      .held_ms          (held[g]),
      .qualified        (qual[g]),
      .settled_released (rel[g])
    );
  end

  // ********************************
  // state and flags
  // ********************************
  pbw_state_type state;
  pbw_state_type next_state;
  logic [1:0]    boot_cnt;
  logic [4:0]    position;
  logic [4:0]    hold_pos;
  logic          dir_up;
  logic          manual_mode;
  logic          dirty;
  logic          store_armed;
  logic          store_veto;
  logic          sd_ok;
  logic          sd_armed;
  logic [TW-1:0] step_tmr;
  logic [TW-1:0] idle_tmr;
  logic [TW-1:0] nv_tmr;
  logic          do_step;
  logic          step_up;
  logic          lock;
  logic          act_prs;
  logic [TW-1:0] act_held;
  logic [TW-1:0] interval;
  logic          start_auto;
  logic          start_manual;

  // the button that owns the current scan
  assign act_prs  = dir_up ? prs[0] : prs[1];
  assign act_held = dir_up ? held[0] : held[1];

  // slow scan for the first second of a hold, fast after
  assign interval = (act_held < `PBW_FAST_AFTER_MS) ?
                    `PBW_SLOW_STEP_MS :
                    `PBW_FAST_STEP_MS;

  // a store pin taken low after a high power-up locks the buttons
  // until it has stayed high for a full debounce window
  assign lock = manual_mode && !rel[2];

  assign start_auto = !manual_mode && prs[2] && dirty &&
                      (idle_tmr >= `PBW_IDLE_SAVE_MS);
  assign start_manual = manual_mode && store_armed && !prs[2]
                        && !store_veto;

  // ********************************
  // sequencer
  // ********************************
  // next state and single step requests
  always_comb begin
    next_state = state;
    do_step    = 1'b0;
    step_up    = dir_up;
    case (state)
      PBW_RECALL: begin
        if (boot_cnt == `PBW_BOOT_WAIT) begin
          next_state = PBW_STANDBY;
        end
      end
      PBW_STANDBY: begin
        if (start_auto || start_manual) begin
          next_state = PBW_STORE;
        end else if (prs[0] && prs[1]) begin
          next_state = PBW_MULTI;
        end else if (!lock && (qual[0] ^ qual[1])) begin
          do_step    = 1'b1;
          step_up    = qual[0];
          next_state = PBW_STEP;
        end
      end
      PBW_STEP: begin
        if (prs[0] && prs[1]) begin
          next_state = PBW_MULTI;
        end else if (!act_prs || lock) begin
          next_state = PBW_STANDBY;
        end else if (tick && (step_tmr >= interval - 1'b1)) begin
          do_step = 1'b1;
        end
      end
      PBW_MULTI: begin
        if (!prs[0] && !prs[1]) begin
          next_state = PBW_STANDBY;
        end else if (sd_ok && (held[0] >= `PBW_SHUTDOWN_MS) &&
                     (held[1] >= `PBW_SHUTDOWN_MS)) begin
          next_state = PBW_SHUTDOWN;
        end
      end
      PBW_SHUTDOWN: begin
        if (sd_armed && (|qual)) begin
          next_state = PBW_WAKE;
        end
      end
      PBW_WAKE: begin
        if (act_prs && (act_held >= `PBW_WAKE_SCAN_MS)) begin
          do_step    = 1'b1;
          next_state = PBW_STEP;
        end else if (!(|prs)) begin
          next_state = PBW_STANDBY;
        end
      end
      PBW_STORE: begin
        // every pin is ignored until the write cycle ends
        if (tick && (nv_tmr >= `PBW_NV_WRITE_MS - 1'b1)) begin
          next_state = PBW_STANDBY;
        end
      end
      default: next_state = PBW_RECALL;
    endcase
  end

  // state register
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state <= PBW_RECALL;
    end else begin
      state <= next_state;
    end
  end

  // boot wait lets the synchronisers fill before pins are sampled
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      boot_cnt    <= '0;
      manual_mode <= 1'b0;
    end else if (state == PBW_RECALL) begin
      boot_cnt <= boot_cnt + 1'b1;
      if (boot_cnt == `PBW_BOOT_WAIT) begin
        manual_mode <= !prs[2]; // store pin high at power-up
      end
    end
  end

  // scan direction, taken when a scan starts or shutdown ends
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      dir_up <= 1'b0;
    end else if ((state == PBW_STANDBY) ||
                 (state == PBW_SHUTDOWN)) begin
      dir_up <= step_up & qual[0] | (state == PBW_SHUTDOWN) & qual[0];
    end
  end

  // ********************************
  // position counter and holding register
  // ********************************
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      position <= `PBW_TOP_TAP;
    end else if ((state == PBW_RECALL) &&
                 (boot_cnt == `PBW_BOOT_WAIT)) begin
      // an erased cell reads as the top tap
      position <= nv_blank ? `PBW_TOP_TAP : nv_recall_data;
    end else if (next_state == PBW_SHUTDOWN) begin
      position <= `PBW_BOTTOM_TAP;
    end else if ((state == PBW_SHUTDOWN) &&
                 (next_state == PBW_WAKE)) begin
      position <= hold_pos;
    end else if (do_step) begin
      if (step_up && (position != `PBW_TOP_TAP)) begin
        position <= position + 1'b1;
      end else if (!step_up && (position != `PBW_BOTTOM_TAP)) begin
        position <= position - 1'b1;
      end
    end
  end

  // keeps the tap held before shutdown, apart from the forced tap
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      hold_pos <= `PBW_TOP_TAP;
    end else if ((next_state == PBW_SHUTDOWN) &&
                 (state != PBW_SHUTDOWN)) begin
      hold_pos <= position;
    end
  end

  // ********************************
  // timers
  // ********************************
  // step spacing, restarted on every step and outside a scan
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      step_tmr <= '0;
    end else if (do_step || (state != PBW_STEP)) begin
      step_tmr <= '0;
    end else if (tick) begin
      step_tmr <= step_tmr + 1'b1;
    end
  end

  // idle time since up or down was last touched
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      idle_tmr <= '0;
    end else if (prs[0] || prs[1]) begin
      idle_tmr <= '0;
    end else if (tick && (idle_tmr < `PBW_IDLE_SAVE_MS)) begin
      idle_tmr <= idle_tmr + 1'b1;
    end
  end

  // length of the write cycle
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      nv_tmr <= '0;
    end else if (state != PBW_STORE) begin
      nv_tmr <= '0;
    end else if (tick) begin
      nv_tmr <= nv_tmr + 1'b1;
    end
  end

  // ********************************
  // store bookkeeping
  // ********************************
  // only a wiper with a step request since the last store is saved by the idle store, so idle does not wear the cell
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      dirty <= 1'b0;
    end else if (next_state == PBW_STORE) begin
      dirty <= 1'b0;
    end else if (do_step) begin
      dirty <= 1'b1;
    end
  end

  // a store press overlapping up or down is vetoed until released
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      store_veto <= 1'b0;
    end else if (!prs[2]) begin
      store_veto <= 1'b0;
    end else if (prs[0] || prs[1]) begin
      store_veto <= 1'b1;
    end
  end

  // manual store armed by a qualified press, fired on release
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      store_armed <= 1'b0;
    end else if ((state == PBW_STORE) || (state == PBW_SHUTDOWN) ||
                 (state == PBW_WAKE) || store_veto) begin
      store_armed <= 1'b0;
    end else if (start_manual && (state == PBW_STANDBY)) begin
      store_armed <= 1'b0;
    end else if (manual_mode && qual[2]) begin
      store_armed <= 1'b1;
    end
  end

  // ********************************
  // shutdown qualification
  // ********************************
  // both presses must begin inside one debounce window
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sd_ok <= 1'b0;
    end else if (!prs[0] || !prs[1]) begin
      sd_ok <= 1'b0;
    end else if (state != PBW_MULTI) begin
      sd_ok <= (held[0] <= `PBW_DEBOUNCE_MS) &&
               (held[1] <= `PBW_DEBOUNCE_MS);
    end
  end

  // wake only counts after all three buttons, store included, are let go
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sd_armed <= 1'b0;
    end else if (state != PBW_SHUTDOWN) begin
      sd_armed <= 1'b0;
    end else if (!(|prs)) begin
      sd_armed <= 1'b1;
    end
  end

  // ********************************
  // outputs
  // ********************************
  // decode and array control, registered
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tap_select           <= 32'h0;
      top_terminal_connect <= 1'b0;
      shutdown_active      <= 1'b0;
      wiper_position       <= `PBW_TOP_TAP;
    end else begin
      tap_select           <= 32'h1 << position;
      top_terminal_connect <= (state != PBW_SHUTDOWN);
      shutdown_active      <= (state == PBW_SHUTDOWN);
      wiper_position       <= position;
    end
  end

  // one-cycle write strobe as the write cycle opens
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      nv_wr      <= '0;
      store_busy <= 1'b0;
    end else begin
      nv_wr.strobe <= (next_state == PBW_STORE) &&
                      (state != PBW_STORE);
      nv_wr.data   <= position;
      store_busy   <= (next_state == PBW_STORE);
    end
  end

endmodule // pbw_wiper_ctrl

//--- sim/pbw_button_model.sv
`timescale 1ns/1ps

// ****
// push-button switches on the three pins
// ****
module pbw_button_model #(
  parameter int TICK_CYCLES = 50,
  parameter int GAP_MS      = 5
) (
  // clock
  input  wire logic          clk_sys,
  // pins toward the controller
  output pbw_pkg::pbw_pins_type pins
);
  import pbw_pkg::*;
  logic       store_lo;  // store switch latched down
  logic [2:0] mask;      // bit0 up, bit1 down, bit2 store
  // a released switch leaves the pin at its pull-up level
  assign pins = ~({store_lo, 2'b00} | mask);
  initial begin
    store_lo = 1'b0;
    mask = 3'h0;
  end
  // press the chosen switches together, hold, release, then rest
  task automatic hold(input logic [2:0] which, input int ms);
    @(posedge clk_sys);
    #1 mask = which;
    repeat (ms * TICK_CYCLES) @(posedge clk_sys);
    #1 mask = 3'h0;
    repeat (GAP_MS * TICK_CYCLES) @(posedge clk_sys);
  endtask
endmodule // pbw_button_model

//--- sim/pbw_wiper_ctrl_asserts.sv
`timescale 1ns/1ps

// ****
// port checker for the wiper controller
// ****
module pbw_wiper_ctrl_chk #(
  parameter int TICK_CYCLES = 50000
) (
  // clock and reset
  input wire logic                   clk_sys,
  input wire logic                   rst_n,
  // pins and non-volatile cell
  input wire pbw_pkg::pbw_pins_type  pins,
  input wire logic [4:0]             nv_recall_data,
  input wire logic                   nv_blank,
  input wire pbw_pkg::pbw_nv_wr_type nv_wr,
  // array control and status
  input wire logic [31:0]            tap_select,
  input wire logic                   top_terminal_connect,
  input wire logic [4:0]             wiper_position,
  input wire logic                   store_busy,
  input wire logic                   shutdown_active
);
  import pbw_pkg::*;
  logic [3:0]  boot_cnt;
  logic        boot_done;
  logic [31:0] press_cnt;
  logic [2:0]  rel_cnt;
  logic [31:0] both_cnt;
  logic [2:0]  sd_hist;
  logic [4:0]  saved_pos;
  logic        any_low;
  assign boot_done = boot_cnt == 4'hA;
  assign any_low = !pins.up_button_n || !pins.down_button_n;
  // cycles since reset, so recall has landed before checking
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) boot_cnt <= 4'h0;
    else if (!boot_done) boot_cnt <= boot_cnt + 4'h1;
  end
  // press length; cleared only after a settled release so the
  // synchroniser lag cannot make a last step look unpressed
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      press_cnt <= 32'h0;
      rel_cnt <= 3'h0;
    end else if (any_low) begin
      press_cnt <= press_cnt + 32'h1;
      rel_cnt <= 3'h0;
    end else if (rel_cnt != 3'h6) rel_cnt <= rel_cnt + 3'h1;
    else press_cnt <= 32'h0;
  end
  // length of the joint up and down press
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) both_cnt <= 32'h0;
    else if (!pins.up_button_n && !pins.down_button_n)
      both_cnt <= both_cnt + 32'h1;
    else both_cnt <= 32'h0;
  end
  // position kept frozen around shutdown for the restore check
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sd_hist <= 3'h0;
      saved_pos <= 5'h1F;
    end else begin
      sd_hist <= {sd_hist[1:0], shutdown_active};
      if (!shutdown_active && sd_hist == 3'h0) saved_pos <= wiper_position;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  // ****
  // assertions
  // ****
  a_tap_decode: assert property (boot_done && !shutdown_active &&
    $stable(wiper_position) |-> tap_select == (32'h1 << wiper_position))
    else $error("tap select does not match position");
  a_step_by_one: assert property (boot_done &&
    $changed(wiper_position) && !shutdown_active && sd_hist == 3'h0 |->
    (wiper_position == $past(wiper_position) + 5'h01 &&
     $past(wiper_position) != 5'h1F) ||
    (wiper_position == $past(wiper_position) - 5'h01 &&
     $past(wiper_position) != 5'h00))
    else $error("position moved by other than one tap");
  a_step_needs_press: assert property (boot_done &&
    $changed(wiper_position) && !shutdown_active && sd_hist == 3'h0
    |-> press_cnt >= 14 * TICK_CYCLES)
    else $error("position moved without a debounced press");
  a_busy_frozen: assert property (store_busy && $past(store_busy) |->
    $stable(wiper_position) && !nv_wr.strobe)
    else $error("activity during write cycle");
  a_strobe_busy: assert property (nv_wr.strobe |->
    ##[0:1] store_busy[*8])
    else $error("write cycle not held after strobe");
  a_strobe_data: assert property (nv_wr.strobe |->
    nv_wr.data == wiper_position ##1 !nv_wr.strobe)
    else $error("store data or pulse wrong");
  a_shut_bottom: assert property (shutdown_active &&
    $past(shutdown_active) |-> tap_select == 32'h1 && !top_terminal_connect)
    else $error("shutdown array state wrong");
  a_shut_entry: assert property ($rose(shutdown_active) |->
    both_cnt >= 1999 * TICK_CYCLES)
    else $error("shutdown without two second joint press");
  a_wake_restore: assert property (
    $fell(shutdown_active) |->
    ##[0:2] wiper_position == saved_pos)
    else $error("position not restored after shutdown");
  a_top_connected: assert property (boot_done && !shutdown_active &&
    sd_hist == 3'h0 |-> top_terminal_connect)
    else $error("top terminal open outside shutdown");
  c_shutdown: cover property ($rose(shutdown_active));
  c_store: cover property (nv_wr.strobe);
  c_bottom: cover property (wiper_position == 5'h00 && !shutdown_active);
endmodule // pbw_wiper_ctrl_chk

bind pbw_wiper_ctrl pbw_wiper_ctrl_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
  .clk_sys(clk_sys), .rst_n(rst_n), .pins(pins),
  .nv_recall_data(nv_recall_data), .nv_blank(nv_blank), .nv_wr(nv_wr),
  .tap_select(tap_select), .top_terminal_connect(top_terminal_connect),
  .wiper_position(wiper_position), .store_busy(store_busy),
  .shutdown_active(shutdown_active));

//--- sim/pbw_wiper_ctrl_tb_top.sv
`timescale 1ns/1ps

// ****
// bench for the wiper controller
// ****
module pbw_wiper_ctrl_tb_top;
  import pbw_pkg::*;
  localparam int TICK = 4;  // short timebase keeps the run small
  logic          clk_sys;
  logic          rst_n;
  pbw_pins_type  pins;
  logic [4:0]    nv_recall_data;
  logic          nv_blank;
  pbw_nv_wr_type nv_wr;
  logic [31:0]   tap_select;
  logic          top_terminal_connect;
  logic [4:0]    wiper_position;
  logic          store_busy;
  logic          shutdown_active;
  int            err_count;
  int            cmp_count;
  int            n_strobe;
  int            n0;
  int            k;
  logic [4:0]    strobe_data;
  logic [4:0]    pos;
  logic [15:0]   lfsr;

  pbw_wiper_ctrl #(.TICK_CYCLES(TICK)) dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .pins(pins),
    .nv_recall_data(nv_recall_data), .nv_blank(nv_blank), .nv_wr(nv_wr),
    .tap_select(tap_select), .top_terminal_connect(top_terminal_connect),
    .wiper_position(wiper_position), .store_busy(store_busy),
    .shutdown_active(shutdown_active));
  pbw_button_model #(.TICK_CYCLES(TICK)) btn (
    .clk_sys(clk_sys), .pins(pins));

  // 50 MHz clock
  initial clk_sys = 1'b0;
  always #10 clk_sys = ~clk_sys;
  // record every write request toward the cell
  always @(posedge clk_sys) begin
    if (nv_wr.strobe === 1'b1) begin
      n_strobe <= n_strobe + 1;
      strobe_data <= nv_wr.data;
    end
  end

  // ****
  // helpers
  // ****
  task check(input string name, input logic [31:0] seen,
             input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task test_done;
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  function automatic logic [15:0] lfsr_next(logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  // step count n in one direction, stopping at the ends
  function automatic logic [4:0] moved(logic [4:0] p, logic up, int n);
    for (int i = 0; i < n; i++) begin
      if (up && p != 5'h1F) p = p + 5'h01;
      else if (!up && p != 5'h00) p = p - 5'h01;
    end
    return p;
  endfunction
  // hold chosen so that exactly k+1 steps land clear of tick jitter
  task automatic scan(input logic up, input int k);
    btn.hold(up ? 3'h1 : 3'h2, k < 4 ? 115 + 250 * k : 1040 + 50 * (k - 4));
    pos = moved(pos, up, k + 1);
    check("position", wiper_position, pos);
    check("tap", tap_select, 32'h1 << pos);
  endtask
  task automatic do_reset(input logic blank, input logic [4:0] stored,
                          input logic store_lo);
    @(posedge clk_sys);
    #1 rst_n = 1'b0;
    nv_blank = blank;
    nv_recall_data = stored;
    btn.store_lo = store_lo;
    repeat (6) @(posedge clk_sys);
    #1 rst_n = 1'b1;
    // outlast the store pin's power-up lock-out in manual mode
    repeat (20 * TICK) @(posedge clk_sys);
  endtask

  // ****
  // main sequence
  // ****
  initial begin
    rst_n = 1'b0;
    nv_blank = 1'b1;
    nv_recall_data = 5'h00;
    err_count = 0;
    cmp_count = 0;
    n_strobe = 0;
    lfsr = 16'hBE93;
    do_reset(1'b1, 5'h00, 1'b0);
    check("blank recall", wiper_position, 5'h1F);
    check("top link", top_terminal_connect, 1'b1);
    btn.hold(3'h1, 10);
    check("short press", wiper_position, 5'h1F);
    btn.hold(3'h1, 30);
    check("top end", wiper_position, 5'h1F);
    btn.hold(3'h2, 30);
    check("one down", wiper_position, 5'h1E);
    pos = 5'h1E;
    scan(1'b0, 13);
    for (int i = 0; i < 5; i++) begin
      lfsr = lfsr_next(lfsr);
      k = int'(lfsr[3:0]) % 14;
      scan(lfsr[4], k);
    end
    btn.hold(3'h3, 100);
    check("multi press", wiper_position, pos);
    check("no shutdown", shutdown_active, 1'b0);
    btn.hold(3'h3, 2100);
    check("shutdown", shutdown_active, 1'b1);
    check("bottom tap", tap_select, 32'h1);
    check("top open", top_terminal_connect, 1'b0);
    btn.hold(3'h1, 400);
    check("wake", shutdown_active, 1'b0);
    pos = moved(pos, 1'b1, 1);
    check("restored", wiper_position, pos);
    n0 = n_strobe;
    btn.hold(3'h4, 30);
    check("manual store", n_strobe, n0 + 1);
    check("store data", strobe_data, pos);
    check("busy", store_busy, 1'b1);
    repeat (20 * TICK) @(posedge clk_sys);
    n0 = n_strobe;
    btn.hold(3'h5, 60);
    check("vetoed store", n_strobe, n0);
    check("locked", wiper_position, pos);
    lfsr = lfsr_next(lfsr);
    do_reset(1'b0, lfsr[4:0] & 5'h1E, 1'b1);
    pos = lfsr[4:0] & 5'h1E;
    check("recall", wiper_position, pos);
    btn.hold(3'h1, 30);
    pos = pos + 5'h01;
    n0 = n_strobe;
    repeat (2100 * TICK) @(posedge clk_sys);
    check("idle save", n_strobe, n0 + 1);
    check("idle data", strobe_data, pos);
    test_done();
  end
  // cut a hang short
  initial begin
    repeat (100000) @(posedge clk_sys);
    err_count++;
    test_done();
  end
endmodule // pbw_wiper_ctrl_tb_top
